// ### design/e1_national_bit_event_logic.sv
`timescale 1ns/1ps
module e1_national_bit_event_logic #(
    parameter int DEBOUNCE_REPEAT = nbe_pkg::DEBOUNCE_REPEAT_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nbe_pkg::APB_AW-1:0] paddr,
    input wire logic [nbe_pkg::APB_DW-1:0] pwdata,
    output logic [nbe_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sa6_valid,
    input wire logic [3:0] sa6_nibble,
    input wire logic sa7_valid,
    input wire logic sa7_bit,
    input wire logic zero_run_active,
    output logic seventh_bit_zero_state,
    output logic irq
);
    import nbe_pkg::*;

    initial begin
        if (DEBOUNCE_REPEAT < 1) begin
            $error("DEBOUNCE_REPEAT must be at least one");
        end
    end

    function automatic logic reg_hit(input logic [APB_AW-1:0] a, input logic [15:0] idx);
        reg_hit = (a == {idx[APB_AW-3:0], 2'b00});
    endfunction

    function automatic logic [7:0] match_vec(input logic [3:0] n);
        logic [7:0] m;
        m = 8'h00;
        m[BIT_ALL_ONES] = (n == PAT_ALL_ONES);
        m[BIT_E] = (n == PAT_E);
        m[BIT_C] = (n == PAT_C);
        m[BIT_A] = (n == PAT_A);
        m[BIT_EIGHT] = (n == PAT_EIGHT);
        // ignore lowest bit: only the upper three bits are compared.
        m[BIT_TWO_THREE] = (n[3:1] == PAT_TWO_THREE_HI);
        m[BIT_ALL_ZERO] = (n == PAT_ALL_ZERO);
        m[BIT_UNLISTED] = (m == 8'h00);
        match_vec = m;
    endfunction

    function automatic logic zero_vote(input logic [SA7_VOTE_DEPTH-1:0] h);
        int z;
        z = 0;
        for (int i = 0; i < SA7_VOTE_DEPTH; i++) begin
            if (!h[i]) begin
                z = z + 1;
            end
        end
        zero_vote = (z >= SA7_VOTE_MIN);
    endfunction

    logic [3:0] deb_value;

    // debounced source: patterns are matched on the filtered nibble only.
    sa6_debounce #(
        .REPEAT(DEBOUNCE_REPEAT)
    ) u_debounce (
        .ref_clk(ref_clk),
        .srst(srst),
        .sample_valid(sa6_valid),
        .sample(sa6_nibble),
        .value(deb_value)
    );

    apb_state_e state_reg;
    apb_state_e state_next;
    logic [APB_DW-1:0] prdata_reg;
    logic [APB_DW-1:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [7:0] pmatch_reg;
    logic [7:0] pmatch_next;
    logic [SA7_VOTE_DEPTH-1:0] hist_reg;
    logic [SA7_VOTE_DEPTH-1:0] hist_next;
    logic sa7_state_reg;
    logic sa7_state_next;
    logic zero_run_reg;
    logic zero_run_next;
    logic [7:0] sa6_status_reg;
    logic [7:0] sa6_status_next;
    logic [7:0] sa6_en_reg;
    logic [7:0] sa6_en_next;
    logic [1:0] ez_status_reg;
    logic [1:0] ez_status_next;
    logic [1:0] ez_en_reg;
    logic [1:0] ez_en_next;
    logic irq_reg;
    logic irq_next;

    logic [7:0] dmatch;
    logic [7:0] sa6_evt;
    logic [1:0] ez_evt;
    logic [APB_DW-1:0] rdata;
    logic hit;
    logic done;
    logic done_wr;
    logic done_rd;

    // Bus slave: the answer comes one cycle into the access phase.
    always_comb begin
        hit = reg_hit(paddr, SA6_STATUS_IDX) || reg_hit(paddr, SA6_ENABLE_IDX)
            || reg_hit(paddr, EZ_STATUS_IDX) || reg_hit(paddr, EZ_ENABLE_IDX);
        rdata = '0;
        if (reg_hit(paddr, SA6_STATUS_IDX)) begin
            rdata[7:0] = sa6_status_reg;
        end else if (reg_hit(paddr, SA6_ENABLE_IDX)) begin
            rdata[7:0] = sa6_en_reg;
        end else if (reg_hit(paddr, EZ_STATUS_IDX)) begin
            rdata[SA7_STATE_BIT] = sa7_state_reg;
            rdata[1:0] = ez_status_reg;
        end else if (reg_hit(paddr, EZ_ENABLE_IDX)) begin
            rdata[1:0] = ez_en_reg;
        end
        done = (state_reg == APB_ANSWER) && psel && penable;
        done_wr = done && pwrite && !pslverr_reg;
        done_rd = done && !pwrite && !pslverr_reg;
    end

    always_comb begin
        state_next = state_reg;
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        case (state_reg)
            APB_IDLE: begin
                if (psel && penable) begin
                    state_next = APB_ANSWER;
                    pready_next = 1'b1;
                    pslverr_next = !hit;
                    prdata_next = pwrite ? '0 : rdata;
                end
            end
            APB_ANSWER: begin
                state_next = APB_IDLE;
            end
            default: begin
                state_next = APB_IDLE;
            end
        endcase
    end

    // Event detection on the debounced nibble, the Sa7 vote and the zero-run level.
    always_comb begin
        dmatch = match_vec(deb_value);
        pmatch_next = dmatch;
        // entry and exit: any change of a listed pattern match is an event.
        sa6_evt = dmatch ^ pmatch_reg;
        // entry only: leaving the unlisted set raises nothing.
        sa6_evt[BIT_UNLISTED] = dmatch[BIT_UNLISTED] && !pmatch_reg[BIT_UNLISTED];
        hist_next = hist_reg;
        if (sa7_valid) begin
            hist_next = {hist_reg[SA7_VOTE_DEPTH-2:0], sa7_bit};
        end
        // two of three: declared while at least two stored samples are zero.
        sa7_state_next = zero_vote(hist_reg);
        zero_run_next = zero_run_active;
        ez_evt = 2'b00;
        // Sa7 change: both declare and removal are events.
        ez_evt[SA7_CHANGE_BIT] = sa7_state_next != sa7_state_reg;
        // zero-run change: detect and clear are both events.
        ez_evt[ZERO_RUN_BIT] = zero_run_active != zero_run_reg;
    end

    // Registers; a read clears only the bits that it actually returned, so an
    // event arriving after the data was captured survives, and a set beats a clear.
    always_comb begin
        sa6_en_next = sa6_en_reg;
        ez_en_next = ez_en_reg;
        sa6_status_next = sa6_status_reg;
        ez_status_next = ez_status_reg;
        // Sa6 enables: one read-write bit per event.
        if (done_wr && reg_hit(paddr, SA6_ENABLE_IDX)) begin
            sa6_en_next = pwdata[7:0];
        end
        // zero-run enables: bits one and zero are writable.
        if (done_wr && reg_hit(paddr, EZ_ENABLE_IDX)) begin
            ez_en_next = pwdata[1:0];
        end
        // clear on read: also writing a one clears a bit.
        if (reg_hit(paddr, SA6_STATUS_IDX)) begin
            if (done_rd) begin
                sa6_status_next = sa6_status_next & ~prdata_reg[7:0];
            end
            if (done_wr) begin
                sa6_status_next = sa6_status_next & ~pwdata[7:0];
            end
        end
        if (reg_hit(paddr, EZ_STATUS_IDX)) begin
            if (done_rd) begin
                ez_status_next = ez_status_next & ~prdata_reg[1:0];
            end
            if (done_wr) begin
                ez_status_next = ez_status_next & ~pwdata[1:0];
            end
        end
        // latch events: hardware set wins over software clear.
        sa6_status_next = sa6_status_next | sa6_evt;
        ez_status_next = ez_status_next | ez_evt;
        // enable gating: only enabled latched events drive the interrupt.
        irq_next = (|(sa6_status_next & sa6_en_next)) || (|(ez_status_next & ez_en_next));
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= APB_IDLE;
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            pmatch_reg <= SA6_MATCH_RST;
            hist_reg <= SA7_HIST_RST;
            sa7_state_reg <= 1'b0;
            zero_run_reg <= 1'b0;
            sa6_status_reg <= SA6_STATUS_RST;
            sa6_en_reg <= SA6_ENABLE_RST;
            ez_status_reg <= EZ_STATUS_RST;
            ez_en_reg <= EZ_ENABLE_RST;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            pmatch_reg <= pmatch_next;
            hist_reg <= hist_next;
            sa7_state_reg <= sa7_state_next;
            zero_run_reg <= zero_run_next;
            sa6_status_reg <= sa6_status_next;
            sa6_en_reg <= sa6_en_next;
            ez_status_reg <= ez_status_next;
            ez_en_reg <= ez_en_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign seventh_bit_zero_state = sa7_state_reg;
    assign irq = irq_reg;

    a_sa6_ones_change: assert property (@(posedge ref_clk) disable iff (srst)
        (dmatch[BIT_ALL_ONES] != pmatch_reg[BIT_ALL_ONES]) |=> sa6_status_reg[BIT_ALL_ONES])
        else $error("Sa6 all-ones change not latched");

    a_pattern_two_three: assert property (@(posedge ref_clk) disable iff (srst)
        (deb_value[3:1] == PAT_TWO_THREE_HI) |-> dmatch[BIT_TWO_THREE]
            && !dmatch[BIT_UNLISTED])
        else $error("Pattern 001x not matched");

    a_unlisted_no_exit: assert property (@(posedge ref_clk) disable iff (srst)
        (!sa6_status_reg[BIT_UNLISTED] && !dmatch[BIT_UNLISTED]) |=> !sa6_status_reg[BIT_UNLISTED])
        else $error("Unlisted event raised without entry");

    a_enable_after_reset: assert property (@(posedge ref_clk)
        $past(srst) |-> (sa6_en_reg == SA6_ENABLE_RST && ez_en_reg == EZ_ENABLE_RST))
        else $error("Enables not zero after reset");

    a_irq_needs_enable: assert property (@(posedge ref_clk) disable iff (srst)
        irq_reg == ((|(sa6_status_reg & sa6_en_reg)) || (|(ez_status_reg & ez_en_reg))))
        else $error("Interrupt does not follow enabled status");

    a_sa7_vote_zero: assert property (@(posedge ref_clk) disable iff (srst)
        ($countones(~hist_reg) >= SA7_VOTE_MIN) |=> seventh_bit_zero_state)
        else $error("Sa7 zero state not declared");

    a_sa7_change_latched: assert property (@(posedge ref_clk) disable iff (srst)
        $changed(sa7_state_reg) |-> ez_status_reg[SA7_CHANGE_BIT])
        else $error("Sa7 change not latched");

    a_zero_run_latched: assert property (@(posedge ref_clk) disable iff (srst)
        $changed(zero_run_reg) |-> ez_status_reg[ZERO_RUN_BIT])
        else $error("Zero-run change not latched");

    a_read_clears_status: assert property (@(posedge ref_clk) disable iff (srst)
        (done_rd && reg_hit(paddr, SA6_STATUS_IDX) && sa6_evt == 8'h00)
            |=> (sa6_status_reg & $past(prdata_reg[7:0])) == 8'h00)
        else $error("Read did not clear returned bits");

    a_ez_enable_write: assert property (@(posedge ref_clk) disable iff (srst)
        (done_wr && reg_hit(paddr, EZ_ENABLE_IDX)) |=> ez_en_reg == $past(pwdata[1:0]))
        else $error("Zero-run enable write lost");

endmodule

// ### design/nbe_pkg.sv
package nbe_pkg;

    localparam int APB_AW = 16;
    localparam int APB_DW = 32;

    // Register indices; byte address is four times the index.
    localparam logic [15:0] SA6_STATUS_IDX = 16'h0b0c;
    localparam logic [15:0] SA6_ENABLE_IDX = 16'h0b0d;
    localparam logic [15:0] EZ_STATUS_IDX = 16'h0b0e;
    localparam logic [15:0] EZ_ENABLE_IDX = 16'h0b0f;

    localparam logic [7:0] SA6_STATUS_RST = 8'h00;
    localparam logic [7:0] SA6_ENABLE_RST = 8'h00;
    localparam logic [1:0] EZ_STATUS_RST = 2'h0;
    localparam logic [1:0] EZ_ENABLE_RST = 2'h0;

    // Sa6 event bit positions, shared by status and enable.
    localparam int BIT_ALL_ONES = 7;
    localparam int BIT_E = 6;
    localparam int BIT_C = 5;
    localparam int BIT_A = 4;
    localparam int BIT_EIGHT = 3;
    localparam int BIT_TWO_THREE = 2;
    localparam int BIT_UNLISTED = 1;
    localparam int BIT_ALL_ZERO = 0;

    localparam logic [3:0] PAT_ALL_ONES = 4'hf;
    localparam logic [3:0] PAT_E = 4'he;
    localparam logic [3:0] PAT_C = 4'hc;
    localparam logic [3:0] PAT_A = 4'ha;
    localparam logic [3:0] PAT_EIGHT = 4'h8;
    localparam logic [2:0] PAT_TWO_THREE_HI = 3'h1;
    localparam logic [3:0] PAT_ALL_ZERO = 4'h0;

    localparam logic [3:0] SA6_DEB_RST = 4'h0;
    localparam logic [7:0] SA6_MATCH_RST = 8'h01;

    localparam int SA7_STATE_BIT = 5;
    localparam int SA7_CHANGE_BIT = 1;
    localparam int ZERO_RUN_BIT = 0;
    localparam int SA7_VOTE_DEPTH = 3;
    localparam int SA7_VOTE_MIN = 2;
    localparam logic [2:0] SA7_HIST_RST = 3'h7;

    localparam int DEBOUNCE_REPEAT_DEFAULT = 3;

    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_ANSWER = 1'b1
    } apb_state_e;

endpackage

// ### design/sa6_debounce.sv
`timescale 1ns/1ps
module sa6_debounce #(
    parameter int REPEAT = nbe_pkg::DEBOUNCE_REPEAT_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic sample_valid,
    input wire logic [3:0] sample,
    output logic [3:0] value
);
    import nbe_pkg::*;

    localparam int CW = $clog2(REPEAT + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(REPEAT);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    initial begin
        if (REPEAT < 1) begin
            $error("REPEAT must be at least one");
        end
    end

    logic [3:0] cand_reg;
    logic [3:0] cand_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic [3:0] value_reg;
    logic [3:0] value_next;

    // repeat before accept: a value is taken only after REPEAT equal multiframes.
    always_comb begin
        cand_next = cand_reg;
        cnt_next = cnt_reg;
        value_next = value_reg;
        if (sample_valid) begin
            if (sample == cand_reg) begin
                if (cnt_reg != CNT_MAX) begin
                    cnt_next = cnt_reg + CNT_ONE;
                end
            end else begin
                cand_next = sample;
                cnt_next = CNT_ONE;
            end
            if (cnt_next == CNT_MAX) begin
                value_next = cand_next;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cand_reg <= SA6_DEB_RST;
            cnt_reg <= '0;
            value_reg <= SA6_DEB_RST;
        end else begin
            cand_reg <= cand_next;
            cnt_reg <= cnt_next;
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

    a_deb_only_repeat: assert property (@(posedge ref_clk) disable iff (srst)
        (value_reg != $past(value_reg)) |-> ($past(cnt_next) == CNT_MAX
            && value_reg == $past(cand_next)))
        else $error("Debounced value changed without enough repeats");

endmodule

// ### testbench/line_source.sv
`timescale 1ns/1ps
module line_source (
    input wire logic ref_clk,
    input wire logic sa6_go,
    input wire logic [3:0] sa6_word,
    input wire logic sa7_go,
    input wire logic sa7_word,
    input wire logic zero_level,
    output logic sa6_valid,
    output logic [3:0] sa6_nibble,
    output logic sa7_valid,
    output logic sa7_bit,
    output logic zero_run_active
);
    // Outside a strobe the data lines carry the inverse, so stale values are never trusted.
    always_ff @(posedge ref_clk) begin
        sa6_valid <= sa6_go;
        sa6_nibble <= sa6_go ? sa6_word : ~sa6_word;
        sa7_valid <= sa7_go;
        sa7_bit <= sa7_go ? sa7_word : ~sa7_word;
        zero_run_active <= zero_level;
    end
endmodule

// ### testbench/tb_e1_national_bit_event_logic.sv
`timescale 1ns/1ps
module tb_e1_national_bit_event_logic;
    import nbe_pkg::*;
    logic ref_clk;
    logic srst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sa6_valid;
    logic [3:0] sa6_nibble;
    logic sa7_valid;
    logic sa7_bit;
    logic zero_run_active;
    logic seventh_bit_zero_state;
    logic irq;
    logic sa6_go;
    logic [3:0] sa6_word;
    logic sa7_go;
    logic sa7_word;
    logic zero_level;
    int fails = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] exp;
    logic [3:0] prev;
    logic [3:0] seq [9] = '{4'hf, 4'he, 4'hc, 4'ha, 4'h8, 4'h2, 4'h3, 4'h5, 4'h0};

    e1_national_bit_event_logic #(.DEBOUNCE_REPEAT(2)) u_dut (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sa6_valid(sa6_valid), .sa6_nibble(sa6_nibble),
        .sa7_valid(sa7_valid), .sa7_bit(sa7_bit), .zero_run_active(zero_run_active),
        .seventh_bit_zero_state(seventh_bit_zero_state), .irq(irq)
    );

    line_source u_line (
        .ref_clk(ref_clk), .sa6_go(sa6_go), .sa6_word(sa6_word), .sa7_go(sa7_go),
        .sa7_word(sa7_word), .zero_level(zero_level),
        .sa6_valid(sa6_valid), .sa6_nibble(sa6_nibble),
        .sa7_valid(sa7_valid), .sa7_bit(sa7_bit), .zero_run_active(zero_run_active)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string msg);
        total_checks++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, want);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic errv);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] want);
        apb(1'b0, idx, 32'h0, rd, err);
        check(rd, want, "register read");
        check({31'h0, err}, 32'h0, "read error flag");
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, rd, err);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic send_sa6(input logic [3:0] n);
        @(posedge ref_clk);
        sa6_go <= 1'b1;
        sa6_word <= n;
        @(posedge ref_clk);
        sa6_go <= 1'b0;
    endtask

    task automatic send_sa7(input logic b);
        @(posedge ref_clk);
        sa7_go <= 1'b1;
        sa7_word <= b;
        @(posedge ref_clk);
        sa7_go <= 1'b0;
    endtask

    task automatic set_zero(input logic v);
        @(posedge ref_clk);
        zero_level <= v;
    endtask

    function automatic logic [7:0] cls(input logic [3:0] n);
        case (n)
            4'hf: cls = 8'h80;
            4'he: cls = 8'h40;
            4'hc: cls = 8'h20;
            4'ha: cls = 8'h10;
            4'h8: cls = 8'h08;
            4'h2, 4'h3: cls = 8'h04;
            4'h0: cls = 8'h01;
            default: cls = 8'h02;
        endcase
    endfunction

    initial begin
        #(20000 * 25);
        fails++;
        end_of_test();
    end

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        sa6_go = 1'b0;
        sa6_word = 4'h5;
        sa7_go = 1'b0;
        sa7_word = 1'b1;
        zero_level = 1'b0;
        wait_clk(6);
        srst <= 1'b0;
        // Reset values.
        rd_chk(SA6_STATUS_IDX, 32'h0);
        rd_chk(SA6_ENABLE_IDX, 32'h0);
        rd_chk(EZ_STATUS_IDX, 32'h0);
        rd_chk(EZ_ENABLE_IDX, 32'h0);
        apb(1'b0, 16'h0b10, 32'h0, rd, err);
        check({31'h0, err}, 32'h1, "unmapped error flag");
        wr(SA6_ENABLE_IDX, 32'hffff_ffff);
        rd_chk(SA6_ENABLE_IDX, 32'hff);
        // A single stray nibble must not pass the debouncer.
        send_sa6(4'hf);
        send_sa6(4'h0);
        send_sa6(4'h0);
        wait_clk(3);
        rd_chk(SA6_STATUS_IDX, 32'h0);
        prev = 4'h0;
        foreach (seq[i]) begin
            send_sa6(seq[i]);
            send_sa6(seq[i]);
            wait_clk(3);
            exp = (cls(prev) != cls(seq[i])) ? ((cls(prev) & 8'hfd) | cls(seq[i])) : 8'h00;
            check({31'h0, irq}, {31'h0, exp != 8'h00}, "sa6 irq");
            rd_chk(SA6_STATUS_IDX, {24'h0, exp});
            rd_chk(SA6_STATUS_IDX, 32'h0);
            prev = seq[i];
        end
        // Masked event still latches but keeps irq low.
        set_zero(1'b1);
        wait_clk(3);
        check({31'h0, irq}, 32'h0, "masked irq");
        wr(EZ_ENABLE_IDX, 32'h3);
        rd_chk(EZ_ENABLE_IDX, 32'h3);
        check({31'h0, irq}, 32'h1, "enabled irq");
        wr(EZ_STATUS_IDX, 32'h1);
        rd_chk(EZ_STATUS_IDX, 32'h0);
        set_zero(1'b0);
        wait_clk(3);
        rd_chk(EZ_STATUS_IDX, 32'h1);
        wait_clk(2);
        check({31'h0, irq}, 32'h0, "irq after clear");
        send_sa7(1'b0);
        wait_clk(4);
        check({31'h0, seventh_bit_zero_state}, 32'h0, "one zero of three");
        send_sa7(1'b0);
        wait_clk(4);
        check({31'h0, seventh_bit_zero_state}, 32'h1, "two zeros of three");
        rd_chk(EZ_STATUS_IDX, 32'h22);
        send_sa7(1'b1);
        wait_clk(4);
        rd_chk(EZ_STATUS_IDX, 32'h20);
        send_sa7(1'b1);
        wait_clk(4);
        rd_chk(EZ_STATUS_IDX, 32'h02);
        check({31'h0, seventh_bit_zero_state}, 32'h0, "state removed");
        end_of_test();
    end
endmodule
